// File: led_scan_pkg.sv
package led_scan_pkg;

    // Register and pixel memory addresses
    localparam logic [15:0] CTRL_ADDR = 16'h00b1;
    localparam logic [15:0] CTRL2_ADDR = 16'h00b2;
    localparam logic [15:0] CFG_ADDR = 16'h00b3;
    localparam logic [15:0] STAT_ADDR = 16'h00b4;
    localparam logic [15:0] RAM_BASE = 16'hc800;

    // Values after reset
    localparam logic [7:0] CTRL_RESET = 8'h07;
    localparam logic [7:0] CTRL2_RESET = 8'h77;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Fields of led_scan_control
    localparam int DUTY_HI = 7;
    localparam int DUTY_LO = 6;
    localparam int PSC_HI = 5;
    localparam int PSC_LO = 4;
    localparam int HOLD_BIT = 3;
    localparam int BRA_HI = 2;
    localparam int BRA_LO = 0;

    // Fields of led_scan_control_second
    localparam int BRM_BIT = 7;
    localparam int BRC_HI = 6;
    localparam int BRC_LO = 4;
    localparam int DMX_BIT = 3;
    localparam int BRB_HI = 2;
    localparam int BRB_LO = 0;

    // Fields of the pin configuration register
    localparam int CFG_HSNK_BIT = 0;
    localparam int CFG_PINFN_BIT = 1;

    // Scan timing; the prescaler limit counts core clocks, the rest LED clock ticks or slots
    localparam logic [5:0] DIV_MAX_M1 = 6'h3f;
    localparam logic [4:0] SLOT_LAST = 5'd16;
    localparam logic [4:0] DEAD_TICKS = 5'd1;
    localparam logic [4:0] USABLE_TICKS = 5'd16;
    localparam logic [3:0] BID_SLOT_BASE = 4'd6;
    localparam logic [3:0] DMX_SLOT_LAST = 4'd7;

    // Active scanning mode
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_BID = 2'b01,
        MODE_DMX = 2'b11
    } mode_t;

endpackage

// File: led_matrix_scan_controller.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Bidirectional and dot matrix modes exist; at most one runs at a time.
// - Bidirectional mode drives four commons and six segments, up to 48 pixels.
// - Duty code 0 off, 1 is 4x4, 2 is 4x5, 3 is 4x6.
// - High-sink enable selects strong sink drive on the LED pins.
// - Brightness-mode bit: 0 uniform, 1 enhanced, in both modes.
// - Segments go inactive for a dead time when the common line changes.
// - Nonzero duty plus LED pin function makes the controller scan pins itself.
// - Scan-hold bit freezes the LED scan clock and holds the scan.
// - Prescaler divides the fast oscillator by 64, 32, 16 or 8.
// - Bidirectional pixels come from six RAM bytes, pixel is 8*offset+bit.
// - Bytes 0..3: low nibble common-positive, high nibble segment-positive.
// - Byte 4 common-positive to segments 4/5; byte 5 segment-4/5 positive.
// - Field A lights most pixels, B even 32..38, C odd 33..39.
// - Each brightness field has eight monotonic levels, 000 darkest.
// - Dot matrix runs when its enable bit is 1 and pins are LED function.
// - Dot matrix scans nine lines, an eight by eight matrix of 64 points.
// - Dot matrix pixels from eight RAM bytes, 1 lights the LED.
// - Dot matrix brightness comes only from field C.
// - Dot matrix segments also get a dead time at line changes.
module led_matrix_scan_controller
    import led_scan_pkg::*;
(
    // Clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    // Register port
    input wire logic [15:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // LED pins
    output logic [9:0] O_LINE_OUT,
    output logic [9:0] O_LINE_OE,
    output logic O_HIGH_SINK
);

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl2_reg;
    logic [7:0] cfg_reg;
    logic [7:0] ram_reg [0:7];
    logic ram_hit;
    logic [2:0] ram_idx;
    logic [7:0] rd_next;
    mode_t mode_reg;
    mode_t mode_next;
    logic active;
    logic restart;
    logic [1:0] duty;
    logic [5:0] presc_reg;
    logic [5:0] div_m1;
    logic tick;
    logic [4:0] cnt_reg;
    logic [3:0] slot_reg;
    logic [3:0] slot_last;
    logic [3:0] slot_next;
    logic wrap;
    logic [9:0] en_reg;
    logic [9:0] val_reg;
    logic [9:0] pwm_reg;
    logic [9:0][2:0] lvl_reg;
    logic [9:0] en_next;
    logic [9:0] val_next;
    logic [9:0] pwm_next;
    logic [9:0][2:0] lvl_next;
    logic [9:0] oe_next;

    // Address decode of the pixel memory
    assign ram_hit = (I_ADDR[15:3] == RAM_BASE[15:3]);
    assign ram_idx = I_ADDR[2:0];
    assign duty = ctrl_reg[DUTY_HI:DUTY_LO];

    // Control registers
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl_reg <= CTRL_RESET;
            ctrl2_reg <= CTRL2_RESET;
            cfg_reg <= CFG_RESET;
        end else if (I_WR) begin
            if (I_ADDR == CTRL_ADDR) begin
                ctrl_reg <= I_WDATA;
            end
            if (I_ADDR == CTRL2_ADDR) begin
                ctrl2_reg <= I_WDATA;
            end
            if (I_ADDR == CFG_ADDR) begin
                cfg_reg <= {6'h00, I_WDATA[1:0]};
            end
        end
    end

    // Pixel memory stays writable while scanning
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            for (int i = 0; i < 8; i++) begin
                ram_reg[i] <= 8'h00;
            end
        end else if (I_WR && ram_hit) begin
            ram_reg[ram_idx] <= I_WDATA;
        end
    end

    // Read multiplexer
    always_comb begin
        rd_next = 8'h00;
        if (ram_hit) begin
            rd_next = ram_reg[ram_idx];
        end else if (I_ADDR == CTRL_ADDR) begin
            rd_next = ctrl_reg;
        end else if (I_ADDR == CTRL2_ADDR) begin
            rd_next = ctrl2_reg;
        end else if (I_ADDR == CFG_ADDR) begin
            rd_next = cfg_reg;
        end else if (I_ADDR == STAT_ADDR) begin
            rd_next = {mode_reg, 2'b00, slot_reg};
        end
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RDATA <= 8'h00;
        end else begin
            O_RDATA <= I_RD ? rd_next : 8'h00;
        end
    end

    // Mode selection, dot matrix takes precedence
    always_comb begin
        if (ctrl2_reg[DMX_BIT]) begin
            mode_next = MODE_DMX;
        end else if (duty != 2'b00) begin
            mode_next = MODE_BID;
        end else begin
            mode_next = MODE_OFF;
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            mode_reg <= MODE_OFF;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign active = (mode_reg != MODE_OFF);
    assign restart = !active || (mode_next != mode_reg) || (slot_reg > slot_last);

    // Prescaler of the LED scan clock
    assign div_m1 = DIV_MAX_M1 >> ctrl_reg[PSC_HI:PSC_LO];
    assign tick = !restart && !ctrl_reg[HOLD_BIT] && (presc_reg == div_m1);

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            presc_reg <= 6'h00;
        end else if (restart || tick || (I_WR && I_ADDR == CTRL_ADDR)) begin
            presc_reg <= 6'h00;
        end else if (!ctrl_reg[HOLD_BIT]) begin
            presc_reg <= presc_reg + 6'h01;
        end
    end

    // Slot sequencing
    assign slot_last = (mode_next == MODE_DMX) ? DMX_SLOT_LAST : BID_SLOT_BASE + {2'b00, duty};
    assign wrap = tick && (cnt_reg == SLOT_LAST);
    assign slot_next = (restart || slot_reg >= slot_last) ? 4'h0 : slot_reg + 4'h1;

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            cnt_reg <= 5'h00;
            slot_reg <= 4'h0;
        end else if (restart) begin
            cnt_reg <= 5'h00;
            slot_reg <= 4'h0;
        end else if (wrap) begin
            cnt_reg <= 5'h00;
            slot_reg <= slot_next;
        end else if (tick) begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end

    // Drive pattern of the coming slot, built from the pixel memory
    always_comb begin
        int n;
        int l;
        l = 0;
        en_next = 10'h000;
        val_next = 10'h000;
        pwm_next = 10'h000;
        lvl_next = '0;
        n = int'(slot_next[1:0]);
        if (mode_next == MODE_DMX) begin
            // Line of this row sources, the other eight sink
            en_next[slot_next] = 1'b1;
            val_next[slot_next] = 1'b1;
            for (int c = 0; c < 8; c++) begin
                l = (c < int'(slot_next)) ? c : c + 1;
                en_next[l] = ram_reg[slot_next[2:0]][c];
                pwm_next[l] = 1'b1;
                lvl_next[l] = ctrl2_reg[BRC_HI:BRC_LO];
            end
        end else if (slot_next < 4'd4) begin
            // Common n positive, segments sink
            en_next[n] = 1'b1;
            val_next[n] = 1'b1;
            for (int k = 0; k < 4; k++) begin
                en_next[4 + k] = ram_reg[n][k];
                pwm_next[4 + k] = 1'b1;
                lvl_next[4 + k] = ctrl_reg[BRA_HI:BRA_LO];
            end
            en_next[8] = (duty >= 2'd2) && ram_reg[4][2 * n];
            pwm_next[8] = 1'b1;
            lvl_next[8] = ctrl2_reg[BRB_HI:BRB_LO];
            en_next[9] = (duty == 2'd3) && ram_reg[4][2 * n + 1];
            pwm_next[9] = 1'b1;
            lvl_next[9] = ctrl2_reg[BRC_HI:BRC_LO];
        end else if (slot_next < 4'd8) begin
            // Common n sinks, segments 0..3 source
            en_next[n] = 1'b1;
            for (int k = 0; k < 4; k++) begin
                en_next[4 + k] = ram_reg[n][4 + k];
                val_next[4 + k] = 1'b1;
                pwm_next[4 + k] = 1'b1;
                lvl_next[4 + k] = ctrl_reg[BRA_HI:BRA_LO];
            end
        end else begin
            // Segment 4 or 5 sources, commons sink
            en_next[slot_next[0] ? 9 : 8] = 1'b1;
            val_next[slot_next[0] ? 9 : 8] = 1'b1;
            for (int k = 0; k < 4; k++) begin
                en_next[k] = ram_reg[5][k + (slot_next[0] ? 4 : 0)];
                pwm_next[k] = 1'b1;
                lvl_next[k] = ctrl_reg[BRA_HI:BRA_LO];
            end
        end
    end

    // Pattern latched at the start of every slot
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            en_reg <= 10'h000;
            val_reg <= 10'h000;
            pwm_reg <= 10'h000;
            lvl_reg <= '0;
        end else if (restart || wrap) begin
            en_reg <= en_next;
            val_reg <= val_next;
            pwm_reg <= pwm_next;
            lvl_reg <= lvl_next;
        end
    end

    // Lit time within a slot for a brightness level
    function automatic logic [4:0] on_len(input logic [2:0] lvl, input logic boost);
        logic [4:0] base;
        base = {1'b0, lvl, 1'b0} + 5'd2;
        if (boost && base != USABLE_TICKS) begin
            on_len = base + 5'd1;
        end else begin
            on_len = base;
        end
    endfunction

    // Window of each PWM pin: dead time first, then lit share; the scanning line drives the whole slot
    always_comb begin
        for (int p = 0; p < 10; p++) begin
            oe_next[p] = active && cfg_reg[CFG_PINFN_BIT] && en_reg[p]
                && (!pwm_reg[p] || ((cnt_reg >= DEAD_TICKS)
                && (cnt_reg < 5'(DEAD_TICKS + on_len(lvl_reg[p], ctrl2_reg[BRM_BIT])))));
        end
    end

    // Registered pin drive
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_LINE_OE <= 10'h000;
            O_LINE_OUT <= 10'h000;
            O_HIGH_SINK <= 1'b0;
        end else begin
            O_LINE_OE <= oe_next;
            O_LINE_OUT <= val_reg & oe_next;
            O_HIGH_SINK <= cfg_reg[CFG_HSNK_BIT];
        end
    end

    // Checks
    sequence slot_begin_s;
        tick && (cnt_reg == SLOT_LAST);
    endsequence

    sequence dead_s;
        active && !restart && (cnt_reg < DEAD_TICKS);
    endsequence

    sequence dmx_latch_s;
        (mode_next == MODE_DMX) && (restart || wrap);
    endsequence

    mode_excl_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        ctrl2_reg[DMX_BIT] |=> (mode_reg == MODE_DMX))
        else $error("dot matrix enable did not win the mode");

    duty_slots_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (mode_reg == MODE_BID) && (duty == 2'd1) |=> (slot_reg < 4'd8))
        else $error("bidirectional slot beyond duty");

    dead_time_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        dead_s |=> ((O_LINE_OE & $past(pwm_reg)) == 10'h000))
        else $error("segment driven during dead time");

    scan_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        ctrl_reg[HOLD_BIT] && !restart |=> $stable(cnt_reg) && $stable(slot_reg))
        else $error("scan moved while held");

    presc_gap_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        tick |=> !tick [*7])
        else $error("scan clock faster than divide by 8");

    slot_wrap_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        slot_begin_s |=> (cnt_reg == 5'h00) ##1 (O_LINE_OE & $past(pwm_reg)) == 10'h000)
        else $error("slot did not restart with dead time");

    bid_common_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (mode_reg == MODE_BID) && !restart && cfg_reg[CFG_PINFN_BIT]
        && (slot_reg == 4'h0) && !wrap |=> O_LINE_OE[0] && O_LINE_OUT[0])
        else $error("common 0 not sourcing in its slot");

    pins_off_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        !cfg_reg[CFG_PINFN_BIT] |=> (O_LINE_OE == 10'h000))
        else $error("pins driven without LED pin function");

    high_sink_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        $rose(cfg_reg[CFG_HSNK_BIT]) |=> O_HIGH_SINK)
        else $error("high sink not following its enable");

    ram_read_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        I_RD && (I_ADDR == RAM_BASE) |=> (O_RDATA == $past(ram_reg[0])))
        else $error("pixel memory read mismatch");

    // Pin drive and slot pattern checks
    hsink_copy_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        1'b1 |=> (O_HIGH_SINK == $past(cfg_reg[CFG_HSNK_BIT])))
        else $error("high sink not a copy of its enable");

    fixed_line_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        dead_s |=> ((O_LINE_OE & ~$past(pwm_reg)) == ($past(en_reg) & ~$past(pwm_reg)
        & {10{$past(cfg_reg[CFG_PINFN_BIT])}})))
        else $error("scanning line not driven through the dead time");

    dmx_dead_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (mode_reg == MODE_DMX) ##0 dead_s |=> ((O_LINE_OE & $past(pwm_reg)) == 10'h000))
        else $error("dot matrix column driven during dead time");

    dmx_nine_lines_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (mode_reg == MODE_DMX) && !restart |=> !O_LINE_OE[9])
        else $error("tenth pin driven in dot matrix mode");

    dmx_level_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        dmx_latch_s |=> pwm_reg[8] && (lvl_reg[8] == $past(ctrl2_reg[BRC_HI:BRC_LO])))
        else $error("dot matrix level not from field C");

    dmx_pixel_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        dmx_latch_s |=> (en_reg[8] == $past(ram_reg[slot_next[2:0]][7])))
        else $error("dot matrix column not taken from pixel memory");

    bid_groups_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (mode_next == MODE_BID) && (restart || wrap) && (slot_next < 4'd4)
        |=> (lvl_reg[8] == $past(ctrl2_reg[BRB_HI:BRB_LO]))
        && (lvl_reg[9] == $past(ctrl2_reg[BRC_HI:BRC_LO])))
        else $error("segment 4 or 5 level from wrong field");

endmodule
`default_nettype wire

// File: led_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// LED panel wired straight to the ten pins; counts the cycles each diode conducts
module led_panel_model (
    // Pins seen from the panel
    input wire logic clk,
    input wire logic clear,
    input wire logic [9:0] line_out,
    input wire logic [9:0] line_oe
);
    int cnt [10][10];
    // A diode conducts only with its anode driven high and its cathode driven low
    always @(posedge clk) begin
        for (int a = 0; a < 10; a++) begin
            for (int k = 0; k < 10; k++) begin
                if (clear)
                    cnt[a][k] = 0;
                else if (line_oe[a] === 1'b1 && line_out[a] === 1'b1 &&
                         line_oe[k] === 1'b1 && line_out[k] === 1'b0)
                    cnt[a][k]++;
            end
        end
    end
endmodule
`default_nettype wire

// File: test_led_matrix_scan_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_led_matrix_scan_controller;
    import led_scan_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic clr = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, d, st;
    logic [9:0] lout, loe, h_out, h_oe;
    logic hsink;
    logic [7:0] ram [8];
    int error_cnt = 0;
    int total_checks = 0;
    int seed = 32'hd1fa;

    led_matrix_scan_controller DUT (.I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_LINE_OUT(lout),
        .O_LINE_OE(loe), .O_HIGH_SINK(hsink));
    led_panel_model panel (.clk(clk), .clear(clr), .line_out(lout), .line_oe(loe));

    // Core clock, 4 ns period
    initial begin
        forever #2 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Register bus cycles; strobes drop one edge after rising
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // Lit ticks per slot for a brightness level
    function automatic int on_len(input int l, input bit e);
        return e ? ((l == 7) ? 16 : 2 * l + 3) : 2 * l + 2;
    endfunction

    // Anode pin * 16 + cathode pin of a pixel, -1 when the duty leaves it out
    function automatic int pin_pair(input int p, input int duty, input bit dot_matrix_mode);
        int n, b;
        n = p / 8;
        b = p % 8;
        if (dot_matrix_mode)
            return n * 16 + ((b < n) ? b : b + 1);
        if (n < 4)
            return (b < 4) ? n * 16 + 4 + b : b * 16 + n;
        if (n == 4)
            return (duty >= 2 + b % 2) ? (b / 2) * 16 + 8 + b % 2 : -1;
        return (duty >= 2 + b / 4) ? (8 + b / 4) * 16 + b % 4 : -1;
    endfunction

    // Random picture, configure, settle one frame, count one frame of lit cycles
    task automatic scan_case(input logic [7:0] c1, input logic [7:0] c2v);
        int ex [10][10];
        int tk, ns, pr, lv, duty;
        bit dot_matrix_mode;
        dot_matrix_mode = c2v[DMX_BIT];
        duty = c1[DUTY_HI:DUTY_LO];
        tk = 64 >> c1[PSC_HI:PSC_LO];
        ns = dot_matrix_mode ? 8 : 7 + duty;
        ex = '{default: 0};
        for (int i = 0; i < 8; i++) begin
            ram[i] = 8'($random(seed));
            wr_reg(RAM_BASE + 16'(i), ram[i]);
            rd_reg(RAM_BASE + 16'(i), d);
            chk("pixel ram", 32'(ram[i]), 32'(d));
        end
        wr_reg(CFG_ADDR, 8'h02);
        wr_reg(CTRL2_ADDR, c2v);
        wr_reg(CTRL_ADDR, c1);
        rd_reg(STAT_ADDR, d);
        chk("mode", dot_matrix_mode ? 32'h3 : 32'(duty != 0), 32'(d[7:6]));
        chk("high sink", 32'h0, 32'(hsink));
        for (int p = 0; p < (dot_matrix_mode ? 64 : 48); p++) begin
            pr = pin_pair(p, duty, dot_matrix_mode);
            lv = dot_matrix_mode ? c2v[BRC_HI:BRC_LO] : (p < 32 || p > 39) ? c1[BRA_HI:BRA_LO] :
                (p % 2) ? c2v[BRC_HI:BRC_LO] : c2v[BRB_HI:BRB_LO];
            if (ram[p / 8][p % 8] && pr >= 0)
                ex[pr / 16][pr % 16] += on_len(lv, c2v[BRM_BIT]) * tk;
        end
        repeat (ns * 17 * tk + 4) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (ns * 17 * tk) @(posedge clk);
        #1;
        for (int a = 0; a < 10; a++)
            for (int k = 0; k < 10; k++)
                chk("lit cycles", ex[a][k], panel.cnt[a][k]);
    endtask

    // Hang guard
    initial begin
        #380000;
        error_cnt++;
        stop_test();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_reg(CTRL_ADDR, d);
        chk("ctrl reset", 32'h07, 32'(d));
        rd_reg(CTRL2_ADDR, d);
        chk("ctrl2 reset", 32'h77, 32'(d));
        wr_reg(16'h00b0, 8'h5a);
        rd_reg(16'h00b0, d);
        chk("unmapped", 32'h0, 32'(d));
        wr_reg(CFG_ADDR, 8'hff);
        rd_reg(CFG_ADDR, d);
        chk("cfg bits", 32'h03, 32'(d));
        chk("high sink", 32'h1, 32'(hsink));
        for (int du = 1; du < 4; du++)
            scan_case({2'(du), 3'b110, 3'($random(seed))}, 8'($random(seed)) & 8'hf7);
        scan_case(8'hf0, 8'hf7);
        scan_case(8'hf7, 8'h07);
        for (int ps = 0; ps < 3; ps++)
            scan_case({2'b01, 2'(ps), 4'b0101}, 8'h35);
        scan_case(8'hc6, 8'h5c);
        scan_case(8'($random(seed)) & 8'hf7, 8'($random(seed)) | 8'h08);
        wr_reg(CTRL_ADDR, 8'hf8);
        repeat (3) @(posedge clk);
        #1 h_out = lout;
        h_oe = loe;
        rd_reg(STAT_ADDR, st);
        repeat (300) @(posedge clk);
        #1 chk("held pins", 32'({h_oe, h_out}), 32'({loe, lout}));
        rd_reg(STAT_ADDR, d);
        chk("held slot", 32'(st), 32'(d));
        wr_reg(CTRL_ADDR, 8'hf0);
        wr_reg(CFG_ADDR, 8'h01);
        repeat (3) @(posedge clk);
        repeat (200) begin
            @(posedge clk);
            #1 chk("pins released", 32'h0, 32'(loe));
        end
        wr_reg(CTRL2_ADDR, 8'h77);
        wr_reg(CTRL_ADDR, 8'h37);
        wr_reg(CFG_ADDR, 8'h02);
        repeat (300) @(posedge clk);
        #1 chk("scan off", 32'h0, 32'(loe));
        stop_test();
    end
endmodule
`default_nettype wire
